// ===== design/tcct_timer.sv
// Three channel 16-bit capture/compare timer with an AHB-Lite slave.
// Assumes a single master, whole-word transfers, and asynchronous pins
// that are synchronised here before any logic reads them.
`timescale 1ns/1ps
module tcct_timer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   input wire logic ext_clock_pin_a,
   input wire logic ext_clock_pin_b,
   input wire logic ext_clock_pin_c,
   input wire logic ext_clock_pin_d,
   input wire logic [2:0] channel_pin_a_i,
   output logic [2:0] channel_pin_a_o,
   output logic [2:0] channel_pin_a_oe,
   input wire logic [2:0] channel_pin_b_i,
   output logic [2:0] channel_pin_b_o,
   output logic [2:0] channel_pin_b_oe,
   output tcct_pkg::tcct_trig_s pattern_output_controller_trig,
   output logic irq
);
   localparam int NCH = tcct_pkg::TCCT_NCH;
   localparam int CW = tcct_pkg::TCCT_CNT_W;
   localparam int IPC = tcct_pkg::TCCT_IRQ_PER_CH;

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic [7:0] addr_ff;
   logic wr_ff;
   logic rd_wait_ff;
   logic [31:0] hrdata_ff;
   logic [31:0] nxt_rdata;
   logic accept;
   logic [2:0] start_ff;
   logic [2:0] sync_ff;
   logic [2:0] pwm_ff;
   logic phase_ff;
   logic [2:0] lvl_a_ff;
   logic [2:0] lvl_b_ff;
   logic [8:0] stat_ff;
   logic [8:0] en_ff;
   logic [8:0] stat_set;
   logic [CW-1:0] cnt_ff [NCH];
   logic [CW-1:0] gra_ff [NCH];
   logic [CW-1:0] grb_ff [NCH];
   tcct_pkg::tcct_ctrl_s ctrl_ff [NCH];
   logic [NCH-1:0] wr_ch;
   logic wr_top;

   assign accept = hsel & htrans[1] & hready;
   // Reads take one wait state so that read data leave a flip-flop.
   assign hreadyout = ~rd_wait_ff;
   assign hresp = tcct_pkg::TCCT_HRESP_OKAY;
   assign hrdata = hrdata_ff;

   // Address phase capture; hsize is not checked, only words are used.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_ff <= 8'h00;
         wr_ff <= 1'b0;
         rd_wait_ff <= 1'b0;
      end else begin
         if (accept) begin
            addr_ff <= haddr[7:0];
         end
         wr_ff <= accept & hwrite;
         rd_wait_ff <= accept & ~hwrite;
      end
   end

   // Read data are sampled during the wait state of a read.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (rd_wait_ff) begin
         hrdata_ff <= nxt_rdata;
      end
   end

   assign wr_top = wr_ff & (addr_ff[7:4] == 4'h0 || addr_ff[7:4] == 4'h1);

   // Read multiplexer; unmapped words and the clear register read zero.
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (addr_ff)
         tcct_pkg::TCCT_OFF_START: nxt_rdata[2:0] = start_ff;
         tcct_pkg::TCCT_OFF_SYNC: nxt_rdata[2:0] = sync_ff;
         tcct_pkg::TCCT_OFF_MODE: begin
            nxt_rdata[2:0] = pwm_ff;
            nxt_rdata[tcct_pkg::TCCT_MODE_PHASE_BIT] = phase_ff;
         end
         tcct_pkg::TCCT_OFF_OUTLVL: nxt_rdata[5:0] = {lvl_b_ff, lvl_a_ff};
         tcct_pkg::TCCT_OFF_IRQ_STAT: nxt_rdata[8:0] = stat_ff;
         tcct_pkg::TCCT_OFF_IRQ_EN: nxt_rdata[8:0] = en_ff;
         default: begin
            for (int c = 0; c < NCH; c++) begin
               if (addr_ff[7:4] == tcct_pkg::TCCT_CH_BASE + 4'(c)) begin
                  unique case (addr_ff[3:2])
                     tcct_pkg::TCCT_SUB_CTRL:
                        nxt_rdata[tcct_pkg::TCCT_CTRL_W-1:0] = ctrl_ff[c];
                     tcct_pkg::TCCT_SUB_CNT: nxt_rdata[CW-1:0] = cnt_ff[c];
                     tcct_pkg::TCCT_SUB_GRA: nxt_rdata[CW-1:0] = gra_ff[c];
                     tcct_pkg::TCCT_SUB_GRB: nxt_rdata[CW-1:0] = grb_ff[c];
                  endcase
               end
            end
         end
      endcase
   end

   // Common control registers; start bits reset to halted. [R18] [R19]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_ff <= 3'h0;
         sync_ff <= 3'h0;
         pwm_ff <= 3'h0;
         phase_ff <= 1'b0;
         en_ff <= 9'h000;
      end else if (wr_top) begin
         if (addr_ff == tcct_pkg::TCCT_OFF_START) begin
            start_ff <= hwdata[2:0];
         end
         if (addr_ff == tcct_pkg::TCCT_OFF_SYNC) begin
            sync_ff <= hwdata[2:0];
         end
         // Channels 0 and 1 have no phase logic, so they ignore it. [R10]
         if (addr_ff == tcct_pkg::TCCT_OFF_MODE) begin
            pwm_ff <= hwdata[2:0];
            phase_ff <= hwdata[tcct_pkg::TCCT_MODE_PHASE_BIT];
         end
         if (addr_ff == tcct_pkg::TCCT_OFF_IRQ_EN) begin
            en_ff <= hwdata[8:0];
         end
      end
   end

   // ****************************************************************
   // Pin synchronisers and prescaler
   // ****************************************************************
   logic [3:0] ext_s1_ff;
   logic [3:0] ext_s2_ff;
   logic [3:0] ext_s3_ff;
   logic [2:0] pa_s1_ff, pa_s2_ff, pa_s3_ff;
   logic [2:0] pb_s1_ff, pb_s2_ff, pb_s3_ff;
   logic [2:0] presc_ff;
   logic [3:0] ext_rise;

   // Two stages cross into hclk; the third stage only serves edges.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_s1_ff <= 4'h0;
         ext_s2_ff <= 4'h0;
         ext_s3_ff <= 4'h0;
         pa_s1_ff <= 3'h0;
         pa_s2_ff <= 3'h0;
         pa_s3_ff <= 3'h0;
         pb_s1_ff <= 3'h0;
         pb_s2_ff <= 3'h0;
         pb_s3_ff <= 3'h0;
      end else begin
         ext_s1_ff <= {ext_clock_pin_d, ext_clock_pin_c,
                       ext_clock_pin_b, ext_clock_pin_a};
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
         pa_s1_ff <= channel_pin_a_i;
         pa_s2_ff <= pa_s1_ff;
         pa_s3_ff <= pa_s2_ff;
         pb_s1_ff <= channel_pin_b_i;
         pb_s2_ff <= pb_s1_ff;
         pb_s3_ff <= pb_s2_ff;
      end
   end

   // Free running divider shared by all channels.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_ff <= 3'h0;
      end else begin
         presc_ff <= presc_ff + 3'h1;
      end
   end

   assign ext_rise = ext_s2_ff & ~ext_s3_ff;

   // Quadrature decode on pins A and B for channel 2. [R11]
   logic qa_step;
   logic qa_up;
   assign qa_step = (ext_s2_ff[0] ^ ext_s3_ff[0]) |
                    (ext_s2_ff[1] ^ ext_s3_ff[1]);
   assign qa_up = ~(ext_s3_ff[0] ^ ext_s2_ff[1]);

   // ****************************************************************
   // Channels
   // ****************************************************************
   logic [NCH-1:0] tick, inc, dec, ld_req, own_clr, clr, load;
   logic [NCH-1:0] match_a, match_b, cap_a, cap_b, ev_a, ev_b, ovf;
   logic sync_clr_any;
   logic sync_load_any;

   // A synchronised preset or clear reaches every synchronised counter.
   assign sync_clr_any = |(own_clr & sync_ff); // [R07]
   assign sync_load_any = |(ld_req & sync_ff); // [R07]
   assign clr = own_clr | (sync_ff & {NCH{sync_clr_any}}); // [R19]
   assign load = ld_req | (sync_ff & {NCH{sync_load_any}}); // [R19]

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      tcct_pkg::tcct_ctrl_s ct;
      logic [1:0] edg_a, edg_b;
      logic sel_a, sel_b;
      assign ct = ctrl_ff[c];
      assign wr_ch[c] = wr_ff &
                        (addr_ff[7:4] == tcct_pkg::TCCT_CH_BASE + 4'(c));
      assign ld_req[c] = wr_ch[c] & (addr_ff[3:2] == tcct_pkg::TCCT_SUB_CNT);

      // Clock source choice. [R02]
      always_comb begin
         unique case (ct.clk_sel)
            tcct_pkg::TCCT_CLK_DIV1: tick[c] = 1'b1;
            tcct_pkg::TCCT_CLK_DIV2: tick[c] = presc_ff[0];
            tcct_pkg::TCCT_CLK_DIV4: tick[c] = &presc_ff[1:0];
            tcct_pkg::TCCT_CLK_DIV8: tick[c] = &presc_ff;
            default: tick[c] = ext_rise[ct.clk_sel[1:0]];
         endcase
      end

      // Phase counting replaces the clock only on channel 2. [R10]
      if (c == 2) begin : g_phase
         assign inc[c] = start_ff[c] & (phase_ff ? qa_step & qa_up : tick[c]);
         assign dec[c] = start_ff[c] & phase_ff & qa_step & ~qa_up;
      end else begin : g_plain
         assign inc[c] = start_ff[c] & tick[c]; // [R17]
         assign dec[c] = 1'b0;
      end

      // Compare fires on the edge that leaves the matching value. [R03]
      assign match_a[c] = (inc[c] | dec[c]) & (~ct.io_a[2] | pwm_ff[c]) &
                          (cnt_ff[c] == gra_ff[c]);
      assign match_b[c] = (inc[c] | dec[c]) & (~ct.io_b[2] | pwm_ff[c]) &
                          (cnt_ff[c] == grb_ff[c]);
      // Edge selection for capture. [R05]
      assign edg_a = {pa_s2_ff[c] & ~pa_s3_ff[c], ~pa_s2_ff[c] & pa_s3_ff[c]};
      assign edg_b = {pb_s2_ff[c] & ~pb_s3_ff[c], ~pb_s2_ff[c] & pb_s3_ff[c]};
      assign sel_a = (ct.io_a[1:0] == tcct_pkg::TCCT_CAP_RISE) ? edg_a[1] :
                     (ct.io_a[1:0] == tcct_pkg::TCCT_CAP_FALL) ? edg_a[0] :
                     |edg_a;
      assign sel_b = (ct.io_b[1:0] == tcct_pkg::TCCT_CAP_RISE) ? edg_b[1] :
                     (ct.io_b[1:0] == tcct_pkg::TCCT_CAP_FALL) ? edg_b[0] :
                     |edg_b;
      assign cap_a[c] = ct.io_a[2] & ~pwm_ff[c] & sel_a; // [R16]
      assign cap_b[c] = ct.io_b[2] & ~pwm_ff[c] & sel_b; // [R16]
      assign ev_a[c] = match_a[c] | cap_a[c];
      assign ev_b[c] = match_b[c] | cap_b[c];
      // Own clear from A or B only. [R06]
      assign own_clr[c] = (ct.clr_sel == tcct_pkg::TCCT_CLR_A & ev_a[c]) |
                          (ct.clr_sel == tcct_pkg::TCCT_CLR_B & ev_b[c]);
      assign ovf[c] = (inc[c] & cnt_ff[c] == tcct_pkg::TCCT_CNT_MAX) |
                      (dec[c] & cnt_ff[c] == tcct_pkg::TCCT_CNT_RST);

      // Counter: preset beats clear, clear beats counting. [R01] [R17]
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cnt_ff[c] <= tcct_pkg::TCCT_CNT_RST;
         end else if (load[c]) begin
            cnt_ff[c] <= hwdata[CW-1:0]; // [R12] [R07]
         end else if (clr[c]) begin
            cnt_ff[c] <= tcct_pkg::TCCT_CNT_RST; // [R06]
         end else if (inc[c]) begin
            cnt_ff[c] <= cnt_ff[c] + 16'h0001; // [R17]
         end else if (dec[c]) begin
            cnt_ff[c] <= cnt_ff[c] - 16'h0001;
         end
      end

      // General registers; a capture wins over a bus write. [R05] [R12]
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            gra_ff[c] <= tcct_pkg::TCCT_GR_RST;
            grb_ff[c] <= tcct_pkg::TCCT_GR_RST;
            ctrl_ff[c] <= '0;
         end else begin
            if (cap_a[c]) begin
               gra_ff[c] <= cnt_ff[c];
            end else if (wr_ch[c] &&
                         addr_ff[3:2] == tcct_pkg::TCCT_SUB_GRA) begin
               gra_ff[c] <= hwdata[CW-1:0];
            end
            if (cap_b[c]) begin
               grb_ff[c] <= cnt_ff[c];
            end else if (wr_ch[c] &&
                         addr_ff[3:2] == tcct_pkg::TCCT_SUB_GRB) begin
               grb_ff[c] <= hwdata[CW-1:0];
            end
            if (wr_ch[c] && addr_ff[3:2] == tcct_pkg::TCCT_SUB_CTRL) begin
               ctrl_ff[c] <= hwdata[tcct_pkg::TCCT_CTRL_W-1:0];
            end
         end
      end

      // Pin levels: software preset, PWM, then compare actions.
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            lvl_a_ff[c] <= 1'b0;
            lvl_b_ff[c] <= 1'b0;
         end else if (wr_top && addr_ff == tcct_pkg::TCCT_OFF_OUTLVL) begin
            lvl_a_ff[c] <= hwdata[c]; // [R13]
            lvl_b_ff[c] <= hwdata[tcct_pkg::TCCT_LVL_B_LSB + c]; // [R13]
         end else begin
            if (pwm_ff[c]) begin
               // Rise at A, fall at B; B wins when both meet. [R08] [R09]
               if (match_b[c]) begin
                  lvl_a_ff[c] <= 1'b0;
               end else if (match_a[c]) begin
                  lvl_a_ff[c] <= 1'b1;
               end
            end else if (match_a[c]) begin
               unique case (ct.io_a[1:0])
                  tcct_pkg::TCCT_CMP_NONE: lvl_a_ff[c] <= lvl_a_ff[c];
                  tcct_pkg::TCCT_CMP_LOW: lvl_a_ff[c] <= 1'b0; // [R04]
                  tcct_pkg::TCCT_CMP_HIGH: lvl_a_ff[c] <= 1'b1; // [R04]
                  tcct_pkg::TCCT_CMP_TOGGLE: lvl_a_ff[c] <= (c == 2) ? 1'b1 :
                                                           ~lvl_a_ff[c];
               endcase
            end
            if (match_b[c] && !pwm_ff[c]) begin
               unique case (ct.io_b[1:0])
                  tcct_pkg::TCCT_CMP_NONE: lvl_b_ff[c] <= lvl_b_ff[c];
                  tcct_pkg::TCCT_CMP_LOW: lvl_b_ff[c] <= 1'b0; // [R04]
                  tcct_pkg::TCCT_CMP_HIGH: lvl_b_ff[c] <= 1'b1; // [R04]
                  tcct_pkg::TCCT_CMP_TOGGLE: lvl_b_ff[c] <= (c == 2) ? 1'b1 :
                                                           ~lvl_b_ff[c];
               endcase
            end
         end
      end

      // Drive a pin only while it is an active compare or PWM output.
      assign channel_pin_a_oe[c] = pwm_ff[c] | (~ct.io_a[2] &
                           (ct.io_a[1:0] != tcct_pkg::TCCT_CMP_NONE)); // [R16]
      assign channel_pin_b_oe[c] = ~ct.io_b[2] &
                           (ct.io_b[1:0] != tcct_pkg::TCCT_CMP_NONE); // [R16]
      assign stat_set[c*IPC + tcct_pkg::TCCT_IRQ_A] = ev_a[c];
      assign stat_set[c*IPC + tcct_pkg::TCCT_IRQ_B] = ev_b[c];
      assign stat_set[c*IPC + tcct_pkg::TCCT_IRQ_OVF] = ovf[c];
   end

   assign channel_pin_a_o = lvl_a_ff;
   assign channel_pin_b_o = lvl_b_ff;

   // ****************************************************************
   // Interrupts and triggers
   // ****************************************************************
   logic [8:0] stat_clr;
   assign stat_clr = (wr_top && addr_ff == tcct_pkg::TCCT_OFF_IRQ_CLR) ?
                     hwdata[8:0] : 9'h000;

   // A new event in the clearing cycle survives. [R14]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_ff <= 9'h000;
      end else begin
         stat_ff <= (stat_ff & ~stat_clr) | stat_set;
      end
   end

   assign irq = |(stat_ff & en_ff); // [R14]

   // Registered one-cycle trigger pulses. [R15]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pattern_output_controller_trig <= '0;
      end else begin
         pattern_output_controller_trig.a <= ev_a;
         pattern_output_controller_trig.b <= ev_b;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_count_step: assert property (inc[0] && !load[0] && !clr[0]
      |=> cnt_ff[0] == $past(cnt_ff[0]) + 16'h0001) // [R17]
      else $error("counter 0 did not advance by one");
   a_halt_holds: assert property (!start_ff[1] && !load[1] && !clr[1]
      |=> cnt_ff[1] == $past(cnt_ff[1])) // [R18]
      else $error("halted counter 1 moved");
   a_wrap_flag: assert property (inc[0] && cnt_ff[0] == 16'hffff &&
      !load[0] && !clr[0] |=> cnt_ff[0] == 16'h0000 && stat_ff[2]) // [R17]
      else $error("wrap did not raise overflow");
   a_capture_copy: assert property (cap_a[1]
      |=> gra_ff[1] == $past(cnt_ff[1])) // [R05]
      else $error("capture did not copy the counter");
   a_clear_zero: assert property (own_clr[0] && !load[0]
      |=> cnt_ff[0] == 16'h0000) // [R06]
      else $error("clear did not zero counter 0");
   a_sync_preset: assert property (ld_req[0] && sync_ff[0] && sync_ff[1]
      |=> cnt_ff[1] == cnt_ff[0]) // [R07]
      else $error("synchronised preset differs");
   a_ch2_no_toggle: assert property (match_a[2] && !pwm_ff[2] &&
      ctrl_ff[2].io_a == 3'h3 && !wr_top |=> lvl_a_ff[2]) // [R04]
      else $error("channel 2 toggled");
   a_pwm_pin_a: assert property (pwm_ff[0] && match_a[0] && !match_b[0] &&
      !wr_top |=> lvl_a_ff[0] && channel_pin_a_oe[0]) // [R09]
      else $error("pwm edge missing on pin a");
   a_set_wins: assert property (stat_set[4] && stat_clr[4]
      |=> stat_ff[4]) // [R14]
      else $error("event lost during clear");
   a_trig_follow: assert property (ev_b[1]
      |=> pattern_output_controller_trig.b[1] ##1
          !$past(ev_b[1]) || pattern_output_controller_trig.b[1]) // [R15]
      else $error("trigger did not follow event");
   a_read_wait: assert property (accept && !hwrite
      |=> !hreadyout ##1 hreadyout) // [R12]
      else $error("read wait state wrong");

   c_match_clear: cover property (own_clr[0] && match_b[0]);
   c_capture: cover property (cap_b[2]);
   c_phase_down: cover property (dec[2] ##[1:20] inc[2]);
   c_sync_clear: cover property (sync_clr_any && clr[1] && clr[2]);
endmodule

// ===== design/tcct_pkg.sv
// Constants, field layouts and carrier types of the three channel
// capture timer. Assumes one AHB-Lite master and a single 250 MHz clock.
// ********************************************************************
// What this block does
// [R01] Three independent channels, each with its own 16-bit up-counter; channel 2 also counts down when phase counting.
// [R02] Each channel picks its clock: undivided, /2, /4, /8 or four pins.
// [R03] Each channel has registers A and B, each compare or capture.
// [R04] Match drives pin 0, 1 or toggle; channel 2 never toggles.
// [R05] Capture copies the counter on rising, falling or both pin edges.
// [R06] Counter clears on a match or capture of its own A or B.
// [R07] Synchronised counters load a preset and clear together.
// [R08] PWM mode gives a duty set by A and B; sync gives three phases.
// [R09] The PWM waveform leaves on the pin belonging to register A.
// [R10] Only channel 2 has phase counting of a two-phase encoder.
// [R11] Phase A comes on external clock pin A, phase B on pin B.
// [R12] Counters and general registers are accessed as whole 16-bit words.
// [R13] Software may set every timer output pin level before counting.
// [R14] Each channel has enabled requests for A, B and overflow: nine.
// [R15] Match and capture events go out as pattern controller triggers.
// [R16] Pin A serves register A and pin B serves register B.
// [R17] A started counter adds one per clock edge, flags wrap to zero.
// [R18] Start bit 0 halts, 1 counts; all start bits reset to 0.
// [R19] Sync bit 0 runs alone; 1 joins synchronous preset and clear.
// ********************************************************************
package tcct_pkg;
   localparam int TCCT_NCH = 3;
   localparam int TCCT_CNT_W = 16;
   localparam int TCCT_DEC_W = 8;
   // Register offsets, byte addresses of aligned words.
   localparam logic [7:0] TCCT_OFF_START = 8'h00;
   localparam logic [7:0] TCCT_OFF_SYNC = 8'h04;
   localparam logic [7:0] TCCT_OFF_MODE = 8'h08;
   localparam logic [7:0] TCCT_OFF_OUTLVL = 8'h0c;
   localparam logic [7:0] TCCT_OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] TCCT_OFF_IRQ_CLR = 8'h14;
   localparam logic [7:0] TCCT_OFF_IRQ_EN = 8'h18;
   // Channel c occupies the 16-byte block whose high nibble is base + c.
   localparam logic [3:0] TCCT_CH_BASE = 4'h2;
   localparam logic [1:0] TCCT_SUB_CTRL = 2'h0;
   localparam logic [1:0] TCCT_SUB_CNT = 2'h1;
   localparam logic [1:0] TCCT_SUB_GRA = 2'h2;
   localparam logic [1:0] TCCT_SUB_GRB = 2'h3;
   // Field positions.
   localparam int TCCT_MODE_PHASE_BIT = 3;
   localparam int TCCT_LVL_B_LSB = 3;
   localparam int TCCT_IRQ_A = 0;
   localparam int TCCT_IRQ_B = 1;
   localparam int TCCT_IRQ_OVF = 2;
   localparam int TCCT_IRQ_PER_CH = 3;
   localparam int TCCT_IRQ_W = 9;
   localparam int TCCT_CTRL_W = 11;
   // Clock select codes; codes 4 to 7 pick external pin A to D.
   localparam logic [2:0] TCCT_CLK_DIV1 = 3'h0;
   localparam logic [2:0] TCCT_CLK_DIV2 = 3'h1;
   localparam logic [2:0] TCCT_CLK_DIV4 = 3'h2;
   localparam logic [2:0] TCCT_CLK_DIV8 = 3'h3;
   // Compare actions (io bit 2 low) and capture edges (io bit 2 high).
   localparam logic [1:0] TCCT_CMP_NONE = 2'h0;
   localparam logic [1:0] TCCT_CMP_LOW = 2'h1;
   localparam logic [1:0] TCCT_CMP_HIGH = 2'h2;
   localparam logic [1:0] TCCT_CMP_TOGGLE = 2'h3;
   localparam logic [1:0] TCCT_CAP_RISE = 2'h0;
   localparam logic [1:0] TCCT_CAP_FALL = 2'h1;
   // Counter clear sources.
   localparam logic [1:0] TCCT_CLR_A = 2'h1;
   localparam logic [1:0] TCCT_CLR_B = 2'h2;
   // Reset values, counter limit and bus response code.
   localparam logic [15:0] TCCT_CNT_RST = 16'h0000;
   localparam logic [15:0] TCCT_CNT_MAX = 16'hffff;
   localparam logic [15:0] TCCT_GR_RST = 16'hffff;
   localparam logic [1:0] TCCT_HRESP_OKAY = 2'h0;

   // Per channel control word; io fields: bit 2 selects capture.
   typedef struct packed {
      logic [2:0] io_b;
      logic [2:0] io_a;
      logic [1:0] clr_sel;
      logic [2:0] clk_sel;
   } tcct_ctrl_s;

   // Trigger pulses to the pattern output controller.
   typedef struct packed {
      logic [TCCT_NCH-1:0] b;
      logic [TCCT_NCH-1:0] a;
   } tcct_trig_s;
endpackage

// ===== testbench/tcct_far_side.sv
// Far side model: capture pulse source and a two-phase encoder.
// Assumes the bench holds each request long enough to pass the sync.
`timescale 1ns/1ps
module tcct_far_side (
   input wire logic clk,
   input wire logic [2:0] cap_req,
   input wire logic step,
   output logic enc_a,
   output logic enc_b,
   output logic [2:0] cap_a
);
   logic [1:0] ph_ff = 2'h0;
   // Gray steps with A leading B, so each step is one forward edge.
   always @(posedge clk) begin
      cap_a <= cap_req;
      if (step) begin
         ph_ff <= ph_ff + 2'h1;
      end
   end
   assign enc_a = ^ph_ff;
   assign enc_b = ph_ff[1];
endmodule

// ===== testbench/test_three_channel_capture_timer.sv
// Self-checking bench for the three channel capture timer.
// Assumes one AHB-Lite master here and the far side model beside it.
`timescale 1ns/1ps
module test_three_channel_capture_timer;
   // ************************************************************
   // Stimulus and checks
   // ************************************************************
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, step = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0] htrans = 0, hresp;
   logic [2:0] cap_req = 0, pa_o, pa_oe, pb_o, pb_oe, pa_i;
   logic hreadyout, irq, ea, eb;
   tcct_pkg::tcct_trig_s trig;
   int err_count = 0, checks_done = 0;
   always #2 hclk = ~hclk;
   tcct_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .ext_clock_pin_a(ea),
      .ext_clock_pin_b(eb), .ext_clock_pin_c(1'b0),
      .ext_clock_pin_d(1'b0), .channel_pin_a_i(pa_i),
      .channel_pin_a_o(pa_o), .channel_pin_a_oe(pa_oe),
      .channel_pin_b_i(pa_i), .channel_pin_b_o(pb_o),
      .channel_pin_b_oe(pb_oe), .pattern_output_controller_trig(trig),
      .irq(irq));
   tcct_far_side far (.clk(hclk), .cap_req(cap_req), .step(step),
      .enc_a(ea), .enc_b(eb), .cap_a(pa_i));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // The master holds each phase until it sees hready high at an edge.
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(0, a, 0);
      check(q, exp);
      check(hresp, 0);
   endtask
   task automatic t_sync_capture();
      bus(1, 8'h04, 3);
      bus(1, 8'h24, 32'h1234);
      rd(8'h34, 32'h1234);
      bus(1, 8'h30, 32'h480);
      cap_req <= 3'h2;
      repeat (4) @(posedge hclk);
      cap_req <= 3'h0;
      repeat (6) @(posedge hclk);
      rd(8'h38, 32'h1234);
      rd(8'h3c, 32'h1234);
      rd(8'h10, 32'h18);
   endtask
   task automatic t_compare();
      int n = 0;
      bus(1, 8'h04, 0);
      bus(1, 8'h24, 32'hfffd);
      bus(1, 8'h28, 5);
      bus(1, 8'h20, 32'h248);
      bus(1, 8'h18, 1);
      bus(1, 8'h00, 1);
      repeat (8) @(posedge hclk);
      // A period of six cycles gives two trigger pulses in twelve.
      repeat (12) begin
         @(posedge hclk);
         if (trig.a[0] === 1'b1) n++;
      end
      check(n, 2);
      check({pa_oe[0], pa_o[0], irq}, 3'h7);
      check({pb_oe[0], pb_o[0]}, 2'h3);
      rd(8'h10, 32'h1f);
      bus(1, 8'h00, 0);
      bus(0, 8'h24, 0);
      check(q <= 5, 1);
      bus(1, 8'h14, 32'h1ff);
      rd(8'h10, 0);
      check(irq, 0);
      bus(1, 8'h0c, 0);
      @(posedge hclk);
      check({pa_o[0], pb_o[0]}, 0);
   endtask
   task automatic t_phase();
      bus(1, 8'h08, 8);
      bus(1, 8'h00, 4);
      repeat (4) begin
         step <= 1;
         @(posedge hclk);
         step <= 0;
         repeat (8) @(posedge hclk);
      end
      rd(8'h44, 4);
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #20000;
      err_count++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1;
      rd(8'h00, 0);
      rd(8'h4c, 32'hffff);
      rd(8'hfc, 0);
      t_sync_capture();
      t_compare();
      t_phase();
      final_report();
   end
endmodule
